// file: pa_cal_defs.vh
// Contract
// - eight power table entries; a 3-bit index limit picks the entry in use.
// - transmit start ramps index from zero up to limit; end ramps back down.
// - amplitude keying counter counts up on one symbols, down on zeros; it indexes the table.
// - shaping counter steps at eight times the symbol rate.
// - shaping counter saturates at the index limit and at zero.
// - autocalibration select calibrates on every synth turn-on or automatic turn-off; the code also calibrates on a return to idle by the idle command.
// - calibrate strobe while idle starts a manual calibration.
// - calibration words survive the sleep modes unchanged.
// - full calibration lasts 735 us at 26 MHz reference, 796 us at 24 MHz.
// - restored calibration words allow synth turn-on in 75 or 81 us.
// - second and third calibration words serve every channel.
// - zero in third word bits [5:4] disables charge pump calibration.
// - charge pump off plus select 01: strobe calibrates VCO only, 168 or 182 us.
`ifndef PA_CAL_DEFS_VH
`define PA_CAL_DEFS_VH

`define CLK_MHZ 16'd40
`define CAL_FULL_26_US 16'd735
`define CAL_FULL_24_US 16'd796
`define CAL_VCO_26_US 16'd168
`define CAL_VCO_24_US 16'd182
`define SETTLE_26_US 16'd75
`define SETTLE_24_US 16'd81

`define REG_TABLE_LAST 5'h07
`define REG_FRONT_END 5'h08
`define REG_SEQUENCER 5'h09
`define REG_SHAPE_DIV 5'h0A
`define REG_CAL_FIRST 5'h0B
`define REG_CAL_SECOND 5'h0C
`define REG_CAL_THIRD 5'h0D
`define REG_COMMAND 5'h0E
`define REG_STATUS 5'h0F

`define LIMIT_MSB 2
`define MOD_MSB 5
`define MOD_LSB 4
`define AUTOCAL_MSB 5
`define AUTOCAL_LSB 4
`define REF_24_BIT 0
`define PUMP_EN_MSB 5
`define PUMP_EN_LSB 4
`define PUMP_RES_MSB 3
`define OOK_ZERO_ENTRY 3'h0
`define OOK_ONE_ENTRY 3'h1
`define SHAPE_FLOOR 3'h0
`define TABLE_DEPTH 8

`define MOD_FSK 2'h0
`define MOD_OOK 2'h1
`define MOD_ASK 2'h2
`define AUTOCAL_NEVER 2'h0
`define AUTOCAL_ON 2'h1
`define AUTOCAL_OFF 2'h2

`define CMD_CAL 8'h01
`define CMD_RX 8'h02
`define CMD_TX 8'h03
`define CMD_IDLE 8'h04
`define CMD_SLEEP 8'h05
`define CMD_WAKE 8'h06

`define RST_BYTE 8'h00
`define RST_FRONT_END 8'h00
`define RST_SEQUENCER 8'h00
`define RST_SHAPE_DIV 8'h00
`define RST_CAL_THIRD 8'h20

`endif

// file: shape_counter.v
`timescale 1ns/10ps
`default_nettype none
module shape_counter (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire clear, // force index to zero
  input wire tick, // step enable
  input wire up, // count direction
  input wire [2:0] limit, // saturation ceiling
  output reg [2:0] index // table index
);
  always @(posedge clk) begin
    if (!rst_n || clear) begin
      index <= 3'h0;
    end else if (tick) begin
      if (up) begin
        if (index < limit) begin
          index <= index + 3'h1;
        end else begin
          index <= limit;
        end
      end else if (index > limit) begin
        index <= limit;
      end else if (index != 3'h0) begin
        index <= index - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: cycle_timer.v
`timescale 1ns/10ps
`default_nettype none
module cycle_timer (
  input wire clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire load, // start a new interval
  input wire abort, // stop without done
  input wire [15:0] count, // interval in cycles
  output reg busy, // interval running
  output reg done // one-cycle pulse at end
);
  reg [15:0] remain;
  always @(posedge clk) begin
    if (!rst_n || abort) begin
      remain <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      remain <= count;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      remain <= remain - 16'h0001;
      done <= (remain == 16'h0002) || (remain < 16'h0002);
      busy <= (remain > 16'h0002);
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: pa_ramp_and_synth_cal.v
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pa_cal_defs.vh"
module pa_ramp_and_synth_cal #(
  parameter [15:0] CAL_FULL_26_CYC = `CAL_FULL_26_US * `CLK_MHZ,
  parameter [15:0] CAL_FULL_24_CYC = `CAL_FULL_24_US * `CLK_MHZ,
  parameter [15:0] CAL_VCO_26_CYC = `CAL_VCO_26_US * `CLK_MHZ,
  parameter [15:0] CAL_VCO_24_CYC = `CAL_VCO_24_US * `CLK_MHZ
) (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // synchronous reset, active low
  input wire [4:0] addr, // register address
  input wire [7:0] wdata, // register write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [7:0] rdata, // read data, cycle after rd
  input wire tx_data, // symbol bit being sent
  input wire tx_end, // pulse: packet finished
  input wire [7:0] cap_result, // synth capacitance result
  input wire [7:0] curr_result, // synth VCO current result
  input wire [3:0] pump_result, // synth charge pump result
  output reg [7:0] pa_level, // power setting to the amplifier
  output reg pa_enable, // amplifier on
  output reg synth_enable, // synthesizer on
  output reg cal_busy, // calibration running
  output reg cal_vco_only, // calibration skips charge pump
  output reg [7:0] cal_word_first, // calibration word to synth
  output reg [7:0] cal_word_second, // calibration word to synth
  output reg [7:0] cal_word_third, // calibration word to synth
  output reg [3:0] radio_state // sequencer state
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_CAL = 4'h1;
  localparam [3:0] ST_SETTLE = 4'h2;
  localparam [3:0] ST_RX = 4'h3;
  localparam [3:0] ST_TX = 4'h4;
  localparam [3:0] ST_RAMP = 4'h5;
  localparam [3:0] ST_SLEEP = 4'h6;
  localparam [15:0] SETTLE_26_CYC = `SETTLE_26_US * `CLK_MHZ;
  localparam [15:0] SETTLE_24_CYC = `SETTLE_24_US * `CLK_MHZ;

  reg [7:0] table_mem [0:7];
  reg [7:0] front_end_config_zero;
  reg [7:0] radio_sequencer_config_zero;
  reg [7:0] shape_div;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [3:0] after_cal;
  reg [3:0] next_after_cal;
  reg [3:0] after_ramp;
  reg [3:0] next_after_ramp;
  reg cal_valid;
  reg [7:0] div_cnt;
  reg timer_load;
  reg [15:0] timer_count;
  reg start_cal;
  reg start_settle;
  wire timer_busy;
  wire timer_done;
  wire [2:0] shape_index;
  wire [2:0] power_index_limit;
  wire [1:0] mod_sel;
  wire [1:0] synth_autocalibration_select;
  wire ref_24;
  wire pump_cal_en;
  wire cmd_wr;
  wire sel_table;
  wire sel_front_end;
  wire sel_sequencer;
  wire sel_shape_div;
  wire sel_cal_first;
  wire sel_cal_second;
  wire sel_cal_third;
  reg [7:0] next_pa_level;
  wire shaping;
  wire shape_tick;
  wire shape_up;
  wire [7:0] cmd;
  reg [15:0] cal_cycles;
  reg [15:0] settle_cycles;
  integer i;

  assign power_index_limit = front_end_config_zero[`LIMIT_MSB:0];
  assign mod_sel = front_end_config_zero[`MOD_MSB:`MOD_LSB];
  assign synth_autocalibration_select = radio_sequencer_config_zero[`AUTOCAL_MSB:`AUTOCAL_LSB];
  assign ref_24 = radio_sequencer_config_zero[`REF_24_BIT];
  assign pump_cal_en = (cal_word_third[`PUMP_EN_MSB:`PUMP_EN_LSB] != 2'h0);
  assign cmd_wr = wr && (addr == `REG_COMMAND);
  assign sel_table = wr && (addr <= `REG_TABLE_LAST);
  assign sel_front_end = wr && (addr == `REG_FRONT_END);
  assign sel_sequencer = wr && (addr == `REG_SEQUENCER);
  assign sel_shape_div = wr && (addr == `REG_SHAPE_DIV);
  assign sel_cal_first = wr && (addr == `REG_CAL_FIRST);
  assign sel_cal_second = wr && (addr == `REG_CAL_SECOND);
  assign sel_cal_third = wr && (addr == `REG_CAL_THIRD);
  assign cmd = cmd_wr ? wdata : 8'h00;
  assign shaping = (state == ST_TX) || (state == ST_RAMP);

  // full calibration time depends on the reference; without pump it is shorter
  always @* begin
    if (pump_cal_en) begin
      cal_cycles = ref_24 ? CAL_FULL_24_CYC : CAL_FULL_26_CYC;
    end else begin
      cal_cycles = ref_24 ? CAL_VCO_24_CYC : CAL_VCO_26_CYC;
    end
    settle_cycles = ref_24 ? SETTLE_24_CYC : SETTLE_26_CYC;
  end

  // shaping tick: shape_div+1 clocks, software sets it to an eighth of a symbol
  assign shape_tick = shaping && (div_cnt == shape_div);
  always @(posedge clk) begin
    if (!rst_n || !shaping || shape_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ramp up while sending, down at the end; amplitude keying follows the bits
  assign shape_up = (state == ST_TX) && ((mod_sel == `MOD_ASK) ? tx_data : 1'b1);

  shape_counter u_shape (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!shaping),
    .tick(shape_tick),
    .up(shape_up),
    .limit(power_index_limit),
    .index(shape_index)
  );

  cycle_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .abort(cmd == `CMD_IDLE),
    .count(timer_count),
    .busy(timer_busy),
    .done(timer_done)
  );

  always @* begin
    next_state = state;
    next_after_cal = after_cal;
    next_after_ramp = after_ramp;
    start_cal = 1'b0;
    start_settle = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cmd == `CMD_CAL) begin
          start_cal = 1'b1;
          next_after_cal = ST_IDLE;
        end else if ((cmd == `CMD_RX) || (cmd == `CMD_TX)) begin
          next_after_cal = (cmd == `CMD_RX) ? ST_RX : ST_TX;
          if (synth_autocalibration_select == `AUTOCAL_ON) begin
            start_cal = 1'b1;
          end else begin
            start_settle = 1'b1;
          end
        end else if (cmd == `CMD_SLEEP) begin
          next_state = ST_SLEEP;
        end
      end
      ST_CAL: begin
        if (cmd == `CMD_IDLE) begin
          next_state = ST_IDLE;
        end else if (timer_done) begin
          next_state = after_cal;
        end
      end
      ST_SETTLE: begin
        if (cmd == `CMD_IDLE) begin
          next_state = ST_IDLE;
        end else if (timer_done) begin
          next_state = after_cal;
        end
      end
      ST_RX: begin
        if (cmd == `CMD_TX) begin
          next_state = ST_TX;
        end else if (cmd == `CMD_IDLE) begin
          if (synth_autocalibration_select == `AUTOCAL_OFF) begin
            start_cal = 1'b1;
            next_after_cal = ST_IDLE;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_TX: begin
        if ((cmd == `CMD_RX) || (cmd == `CMD_IDLE) || tx_end) begin
          next_state = ST_RAMP;
          next_after_ramp = (cmd == `CMD_RX) ? ST_RX : ST_IDLE;
        end
      end
      ST_RAMP: begin
        if (shape_index == `SHAPE_FLOOR) begin
          if (after_ramp == ST_RX) begin
            next_state = ST_RX;
          end else if (synth_autocalibration_select == `AUTOCAL_OFF) begin
            start_cal = 1'b1;
            next_after_cal = ST_IDLE;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_SLEEP: begin
        // calibration words are left untouched while asleep
        if (cmd == `CMD_WAKE) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (start_cal) begin
      next_state = ST_CAL;
    end else if (start_settle) begin
      next_state = ST_SETTLE;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      after_cal <= ST_IDLE;
      after_ramp <= ST_IDLE;
      timer_load <= 1'b0;
      timer_count <= 16'h0000;
    end else begin
      state <= next_state;
      after_cal <= next_after_cal;
      after_ramp <= next_after_ramp;
      timer_load <= start_cal || start_settle;
      timer_count <= start_cal ? cal_cycles : settle_cycles;
    end
  end

  // register writes; a calibration finishing in the same cycle wins
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < `TABLE_DEPTH; i = i + 1) begin
        table_mem[i] <= `RST_BYTE;
      end
      front_end_config_zero <= `RST_FRONT_END;
      radio_sequencer_config_zero <= `RST_SEQUENCER;
      shape_div <= `RST_SHAPE_DIV;
      cal_word_first <= `RST_BYTE;
      cal_word_second <= `RST_BYTE;
      cal_word_third <= `RST_CAL_THIRD;
      cal_valid <= 1'b0;
    end else begin
      if (sel_table) begin
        table_mem[addr[2:0]] <= wdata;
      end
      if (sel_front_end) begin
        front_end_config_zero <= wdata;
      end
      if (sel_sequencer) begin
        radio_sequencer_config_zero <= wdata;
      end
      if (sel_shape_div) begin
        shape_div <= wdata;
      end
      if ((state == ST_CAL) && timer_done) begin
        cal_word_first <= cap_result;
        cal_word_second <= curr_result;
        if (pump_cal_en) begin
          cal_word_third <= {cal_word_third[7:`PUMP_RES_MSB+1], pump_result};
        end
        cal_valid <= 1'b1;
      end else begin
        // restored words make the synth usable without calibrating
        if (sel_cal_first) begin
          cal_word_first <= wdata;
          cal_valid <= 1'b1;
        end
        if (sel_cal_second) begin
          cal_word_second <= wdata;
        end
        if (sel_cal_third) begin
          cal_word_third <= wdata;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr <= `REG_TABLE_LAST) begin
        rdata <= table_mem[addr[2:0]];
      end else begin
        case (addr)
          `REG_FRONT_END: rdata <= front_end_config_zero;
          `REG_SEQUENCER: rdata <= radio_sequencer_config_zero;
          `REG_SHAPE_DIV: rdata <= shape_div;
          `REG_CAL_FIRST: rdata <= cal_word_first;
          `REG_CAL_SECOND: rdata <= cal_word_second;
          `REG_CAL_THIRD: rdata <= cal_word_third;
          `REG_STATUS: rdata <= {shape_index, cal_valid, state};
          default: rdata <= 8'h00;
        endcase
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // power entry for the next cycle; on-off keying bypasses the shaping counter in the transmit state only
  always @* begin
    if (!shaping) begin
      next_pa_level = 8'h00;
    end else if ((mod_sel == `MOD_OOK) && (state == ST_TX)) begin
      next_pa_level = tx_data ? table_mem[`OOK_ONE_ENTRY] : table_mem[`OOK_ZERO_ENTRY];
    end else begin
      next_pa_level = table_mem[shape_index];
    end
  end

  // output stage
  always @(posedge clk) begin
    if (!rst_n) begin
      pa_level <= 8'h00;
      pa_enable <= 1'b0;
      synth_enable <= 1'b0;
      cal_busy <= 1'b0;
      cal_vco_only <= 1'b0;
      radio_state <= ST_IDLE;
    end else begin
      pa_level <= next_pa_level;
      pa_enable <= shaping;
      synth_enable <= (state == ST_CAL) || (state == ST_SETTLE) || (state == ST_RX) || shaping;
      cal_busy <= (state == ST_CAL) && timer_busy;
      cal_vco_only <= (state == ST_CAL) && !pump_cal_en;
      radio_state <= state;
    end
  end
endmodule
`default_nettype wire

// file: pa_cal_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pa_cal_chk #(
  parameter [15:0] CAL_FULL_24_CYC = 16'h0018
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [4:0] addr, // address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic [7:0] pa_level, // power setting
  input wire logic pa_enable, // amplifier on
  input wire logic synth_enable, // synth on
  input wire logic cal_busy, // cal running
  input wire logic cal_vco_only, // vco-only cal
  input wire logic [7:0] cal_word_first, // cal word
  input wire logic [7:0] cal_word_third, // cal word
  input wire logic [3:0] radio_state // state
);
  localparam int CAL_MAX = CAL_FULL_24_CYC + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PA_STATE: assert property (pa_enable == (radio_state == 4'h4 || radio_state == 4'h5))
    else $error("amplifier state mismatch");
  AST_PA_QUIET: assert property (!pa_enable |-> pa_level == 8'h00)
    else $error("power level outside transmit");
  AST_SYNTH_ON: assert property (synth_enable == (radio_state >= 4'h1 && radio_state <= 4'h5))
    else $error("synth enable mismatch");
  AST_VCO_ONLY: assert property (cal_vco_only |-> radio_state == 4'h1 && cal_word_third[5:4] == 2'b00)
    else $error("vco-only cal without pump disabled");
  AST_CAL_CMD: assert property (wr && addr == 5'h0E && wdata == 8'h01 && radio_state == 4'h0 |-> ##2 radio_state == 4'h1)
    else $error("manual cal not started");
  AST_BUSY_STATE: assert property ($rose(cal_busy) |-> radio_state == 4'h1)
    else $error("cal busy outside cal state");
  AST_CAL_BOUND: assert property ($rose(radio_state == 4'h1) |-> ##[1:CAL_MAX] radio_state != 4'h1)
    else $error("cal too long");
  AST_SLEEP_KEEP: assert property (radio_state == 4'h6 && $past(radio_state) == 4'h6 && !$past(wr)
    && !$past(wr, 2) |-> $stable(cal_word_first) && $stable(cal_word_third))
    else $error("cal words lost in sleep");
  AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
endmodule
`default_nettype wire

// file: test_pa_ramp_and_synth_cal.sv
`timescale 1ns/10ps
`default_nettype none
module test_pa_ramp_and_synth_cal;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_data = 1'b0;
  logic tx_end = 1'b0;
  logic [7:0] cap_result = 8'hA5;
  logic [7:0] curr_result = 8'h3C;
  logic [3:0] pump_result = 4'h9;
  wire logic [7:0] rdata, pa_level, cal_word_first, cal_word_second, cal_word_third;
  wire logic pa_enable, synth_enable, cal_busy, cal_vco_only;
  wire logic [3:0] radio_state;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] q[$];
  logic [7:0] e[$];
  pa_ramp_and_synth_cal #(.CAL_FULL_26_CYC(16'h0014), .CAL_FULL_24_CYC(16'h0018), .CAL_VCO_26_CYC(16'h0008),
    .CAL_VCO_24_CYC(16'h000A)) u_pa_ramp_and_synth_cal (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .tx_data(tx_data), .tx_end(tx_end), .cap_result(cap_result),
    .curr_result(curr_result), .pump_result(pump_result), .pa_level(pa_level), .pa_enable(pa_enable),
    .synth_enable(synth_enable), .cal_busy(cal_busy), .cal_vco_only(cal_vco_only),
    .cal_word_first(cal_word_first), .cal_word_second(cal_word_second), .cal_word_third(cal_word_third),
    .radio_state(radio_state));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [4:0] a, input logic [7:0] x, input string m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, x, m);
  endtask
  task wait_st(input logic [3:0] s, input int lim, output int n);
    n = 0;
    while (radio_state !== s && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({4'h0, radio_state}, {4'h0, s}, "state");
  endtask
  // records every change of the power output over n cycles
  task watch(input int n);
    logic [7:0] last;
    last = pa_level;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (pa_level !== last) q.push_back(pa_level);
      last = pa_level;
    end
  endtask
  task t_regs;
    chk(cal_word_third, 8'h20, "third reset");
    rreg(5'h0D, 8'h20, "third read");
    rreg(5'h10, 8'h00, "unmapped");
    wreg(5'h0F, 8'hFF);
    rreg(5'h0F, 8'h00, "status");
    $display("done regs");
  endtask
  task t_ramp(input logic [2:0] lim, input logic use_end);
    int n;
    for (int i = 0; i < 8; i++) wreg(i[4:0], 8'h10 + i[7:0]);
    wreg(5'h08, {5'h00, lim});
    wreg(5'h0A, 8'h03);
    wreg(5'h09, 8'h00);
    q.delete();
    e.delete();
    for (int i = 0; i <= lim; i++) e.push_back(8'h10 + i[7:0]);
    for (int i = lim - 1; i >= 0; i--) e.push_back(8'h10 + i[7:0]);
    e.push_back(8'h00);
    wreg(5'h0E, 8'h03);
    watch(3080);
    if (use_end) begin
      @(posedge clk);
      tx_end <= 1'b1;
      @(posedge clk);
      tx_end <= 1'b0;
    end else begin
      wreg(5'h0E, 8'h04);
    end
    watch(40);
    wreg(5'h0E, 8'h04);
    wait_st(4'h0, 10, n);
    chk(q.size(), e.size(), "ramp steps");
    for (int i = 0; i < e.size() && i < q.size(); i++) chk(q[i], e[i], "ramp level");
    $display("done ramp");
  endtask
  task t_keying;
    int n;
    wreg(5'h08, 8'h10);
    wreg(5'h0E, 8'h03);
    wait_st(4'h4, 3100, n);
    tx_data <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(pa_level, 8'h10, "ook zero");
    tx_data <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(pa_level, 8'h11, "ook one");
    chk({6'h00, pa_enable, synth_enable}, 8'h03, "tx enables");
    wreg(5'h08, 8'h27);
    wreg(5'h0A, 8'h07);
    tx_data <= 1'b0;
    repeat (80) @(posedge clk);
    tx_data <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk({7'h00, pa_level < 8'h13}, 8'h01, "shape rate");
    repeat (80) @(posedge clk);
    #1;
    chk(pa_level, 8'h17, "ask top");
    tx_data <= 1'b0;
    repeat (80) @(posedge clk);
    #1;
    chk(pa_level, 8'h10, "ask bottom");
    wreg(5'h0E, 8'h04);
    wait_st(4'h0, 20, n);
    $display("done keying");
  endtask
  task t_cal;
    int n;
    for (int r = 0; r < 2; r++) begin
      wreg(5'h0D, 8'h20);
      wreg(5'h09, r[7:0]);
      wreg(5'h0E, 8'h01);
      wait_st(4'h1, 5, n);
      wait_st(4'h0, 40, n);
      chk({7'h00, n >= (r ? 23 : 19) && n <= (r ? 27 : 23)}, 8'h01, "full cal time");
      chk(cal_word_first, 8'hA5, "cap word");
      chk(cal_word_second, 8'h3C, "curr word");
      chk(cal_word_third, 8'h29, "pump word");
      wreg(5'h0D, 8'h00);
      wreg(5'h09, 8'h10 | r[7:0]);
      wreg(5'h0E, 8'h02);
      wait_st(4'h1, 5, n);
      chk({7'h00, cal_vco_only}, 8'h01, "vco only");
      @(posedge clk);
      #1;
      chk({7'h00, cal_busy}, 8'h01, "cal busy");
      wait_st(4'h3, 40, n);
      chk({7'h00, n >= (r ? 9 : 7) && n <= (r ? 13 : 11)}, 8'h01, "vco cal time");
      wreg(5'h0E, 8'h04);
      wait_st(4'h0, 10, n);
    end
    wreg(5'h09, 8'h20);
    wreg(5'h0E, 8'h02);
    wait_st(4'h3, 3100, n);
    wreg(5'h0E, 8'h04);
    wait_st(4'h1, 5, n);
    wait_st(4'h0, 40, n);
    $display("done cal");
  endtask
  task t_sleep;
    int n;
    wreg(5'h0B, 8'h5A);
    wreg(5'h0C, 8'h4B);
    wreg(5'h0E, 8'h05);
    wait_st(4'h6, 5, n);
    repeat (10) @(posedge clk);
    wreg(5'h0E, 8'h06);
    wait_st(4'h0, 5, n);
    chk(cal_word_first, 8'h5A, "first kept");
    chk(cal_word_second, 8'h4B, "second kept");
    rreg(5'h0F, 8'h10, "cal valid");
    $display("done sleep");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_ramp(3'h3, 1'b0);
    t_ramp(3'h0, 1'b1);
    t_keying;
    t_cal;
    t_sleep;
    end_sim;
  end
endmodule
bind pa_ramp_and_synth_cal pa_cal_chk #(.CAL_FULL_24_CYC(CAL_FULL_24_CYC)) u_pa_cal_chk (.clk(clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_level(pa_level),
  .pa_enable(pa_enable), .synth_enable(synth_enable), .cal_busy(cal_busy), .cal_vco_only(cal_vco_only),
  .cal_word_first(cal_word_first), .cal_word_third(cal_word_third), .radio_state(radio_state));
`default_nettype wire
